// *** design/enc_setup_params.svh ***
// offsets, field positions, reset value and timing counts for the
// encoder path setup block; included by the word buffer and setup design files
`ifndef ENC_SETUP_PARAMS_SVH
`define ENC_SETUP_PARAMS_SVH

`define REG_PATH_SETUP   8'hE0
`define REG_DAC_IN       8'hE7
`define REG_DELTA_IN     8'hE8

`define PATH_SETUP_RST   16'h0000

`define F_DECIM          15
`define F_PCM_HI         14
`define F_PCM_LO         13
`define F_LOOP_HI        12
`define F_LOOP_LO        11
`define F_LDO_HI         10
`define F_LDO_LO         9
`define F_IDLE           8
`define F_DECAY_HI       7
`define F_DECAY_LO       5
`define F_ATK_HI         4
`define F_ATK_LO         3
`define F_VOUT_HI        2
`define F_VOUT_LO        1
`define F_OVERRIDE       0

// decay base of 128 bit periods is 128/(rate in kbps) ms
`define DECAY_BASE_BITS  15'h0080
`define ATTACK_MIN_SHIFT 3'h2
`define BYTE_TOP_BIT     3'h7
`define PBUF_FULL        2'h2

`endif

// *** design/enc_setup_pkg.sv ***
// types shared by the encoder path setup block and its word buffer
// assumes enc_setup_params.svh is on the include path
`default_nettype none

package enc_setup_pkg;

   typedef logic [15:0] word_t;
   typedef logic [14:0] tc_t;

   typedef enum logic [1:0] {
      LOOP_FROM_CMP  = 2'h0,
      LOOP_FROM_HOST = 2'h1,
      LOOP_FROM_FB0  = 2'h2,
      LOOP_FROM_FB1  = 2'h3
   } loop_src_e;

   typedef enum logic [1:0] {
      LDO_EST    = 2'h0,
      LDO_SUM    = 2'h1,
      LDO_DIRECT = 2'h2,
      LDO_INTERP = 2'h3
   } ldo_sel_e;

   typedef enum logic [1:0] {
      VOICE_DETECT = 2'h0,
      VOICE_BITS   = 2'h1,
      VOICE_LOW    = 2'h2,
      VOICE_HIGH   = 2'h3
   } voice_src_e;

endpackage : enc_setup_pkg

`default_nettype wire

// *** design/pcm_buf_if.sv ***
// valid/ready carrier between the setup block and its word buffer
// assumes both ends run on the same clock
`default_nettype none

interface pcm_buf_if;
   import enc_setup_pkg::*;

   word_t in_data;
   logic  in_valid;
   logic  in_ready;
   word_t out_data;
   logic  out_valid;
   logic  out_ready;

   modport buffer (
      input  in_data,
      input  in_valid,
      output in_ready,
      output out_data,
      output out_valid,
      input  out_ready
   );

   modport user (
      output in_data,
      output in_valid,
      input  in_ready,
      input  out_data,
      input  out_valid,
      output out_ready
   );

endinterface : pcm_buf_if

`default_nettype wire

// *** design/pcm_word_buffer.sv ***
// two-entry word buffer in front of the interpolating filter
// assumes mclk domain on both sides
`default_nettype none
`include "enc_setup_params.svh"

module pcm_word_buffer
   import enc_setup_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   pcm_buf_if.buffer        bus
);

   word_t      mem_r [2];
   logic       wr_ptr_r;
   logic       rd_ptr_r;
   logic [1:0] count_r;
   logic       push;
   logic       pop;

   assign bus.in_ready  = (count_r != `PBUF_FULL);
   assign bus.out_valid = (count_r != 2'h0);
   assign bus.out_data  = mem_r[rd_ptr_r];
   assign push          = bus.in_valid & bus.in_ready;
   assign pop           = bus.out_valid & bus.out_ready;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mem_r[0] <= 16'h0000;
         mem_r[1] <= 16'h0000;
      end else if (push) begin
         mem_r[wr_ptr_r] <= bus.in_data;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= 1'h0;
         rd_ptr_r <= 1'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         count_r <= 2'h0;
      end else if (push && !pop) begin
         count_r <= count_r + 2'h1;
      end else if (pop && !push) begin
         count_r <= count_r - 2'h1;
      end
   end

   a_buf_level_bound: assert property (@(posedge mclk) disable iff (rst)
      count_r <= `PBUF_FULL)
      else $error("word buffer level above two");

   a_buf_first_word: assert property (@(posedge mclk) disable iff (rst)
      (push && count_r == 2'h0) |=> (bus.out_valid && bus.out_data == $past(bus.in_data)))
      else $error("word buffer lost first word");

endmodule : pcm_word_buffer

`default_nettype wire

// *** design/enc_path_setup.sv ***
// encoder mode and setup word: decode and datapath steering
// assumes register port, engine strobes and filter words on mclk;
// only the comparator pin comes from outside the clock domain
//
// Notes on behaviour
// - bit 14 low: decimate estimator into output
// - select 10: interpolate words from burst receive
// - select 11: interpolate words host writes
// - interpolating transcodes to delta, decimating from it
// - loop select 00: comparator feeds the encoder
// - loop select 01: host bits, loop opened
// - loop bit 12 set: transcode feedback input
// - output select 00: estimator alone
// - output select 01: estimator plus interpolator
// - select 10 direct test, 11 interpolated words
// - idle enhance bit enables offset tracking
// - decay is 128 periods doubled per code
// - attack is decay over 4, 8, 16, 32
// - voice pin: detect, bits, low, high
// - bit 0 outputs host byte bits instead
// - bit 15 decimates by four, else eight
`default_nettype none
`include "enc_setup_params.svh"

module enc_path_setup
   import enc_setup_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata_r,
   input  wire logic        bit_tick,
   input  wire logic        comparator_in,
   input  wire logic        feedback_bit,
   input  wire logic        encoded_bit,
   input  wire logic        voice_detect,
   input  wire logic [15:0] est_word,
   input  wire logic [15:0] interp_word,
   input  wire logic [15:0] rx_pcm_word,
   input  wire logic        rx_pcm_valid,
   output logic             rx_pcm_ready_r,
   input  wire logic        interp_req,
   output logic      [15:0] interp_pcm_word_r,
   output logic             interp_pcm_valid_r,
   output logic             pcm_decimate_r,
   output logic             decim_by4_r,
   output logic             pcm_to_delta_r,
   output logic             delta_to_pcm_r,
   output logic             loop_open_r,
   output logic             loop_bit_r,
   output logic      [15:0] local_dec_word_r,
   output logic             direct_test_r,
   output logic             offset_track_en_r,
   output logic      [14:0] decay_bits_r,
   output logic      [14:0] attack_bits_r,
   output logic             voice_pin_r,
   output logic             delta_out_r
);

   word_t      setup_r;
   word_t      dac_word_r;
   logic [7:0] delta_byte_r;
   logic [2:0] bit_idx_r;
   logic       cmp_s1_r;
   logic       cmp_s2_r;
   logic       wr_setup;
   logic       wr_dac;
   logic       wr_delta;
   logic       burst_sel;
   logic       host_sel;
   logic       rx_ready_nxt;
   loop_src_e  loop_src;
   ldo_sel_e   ldo_sel;
   voice_src_e voice_src;
   tc_t        decay_nxt;
   tc_t        attack_nxt;
   word_t      ldo_nxt;

   pcm_buf_if pbuf ();

   function automatic logic byte_bit(input logic [7:0] b, input logic [2:0] i);
      byte_bit = b[i];
   endfunction : byte_bit

   pcm_word_buffer u_buf (
      .mclk (mclk),
      .rst  (rst),
      .bus  (pbuf)
   );

   // register decode
   always_comb begin
      wr_setup = 1'h0;
      wr_dac   = 1'h0;
      wr_delta = 1'h0;
      if (reg_addr == `REG_PATH_SETUP) begin
         wr_setup = reg_wr;
      end else if (reg_addr == `REG_DAC_IN) begin
         wr_dac = reg_wr;
      end else if (reg_addr == `REG_DELTA_IN) begin
         wr_delta = reg_wr;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         setup_r <= `PATH_SETUP_RST;
      end else if (wr_setup) begin
         setup_r <= reg_wdata;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata_r <= 16'h0000;
      end else if (reg_rd) begin
         if (reg_addr == `REG_PATH_SETUP) begin
            reg_rdata_r <= setup_r;
         end else if (reg_addr == `REG_DELTA_IN) begin
            reg_rdata_r <= {8'h00, delta_byte_r};
         end else begin
            reg_rdata_r <= 16'h0000;
         end
      end
   end

   // direct test word and host bit byte
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dac_word_r <= 16'h0000;
      end else if (wr_dac) begin
         dac_word_r <= reg_wdata;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         delta_byte_r <= 8'h00;
      end else if (wr_delta) begin
         delta_byte_r <= reg_wdata[7:0];
      end
   end

   // msb first so 55 hex leaves as 0101...; byte repeats until rewritten
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bit_idx_r <= `BYTE_TOP_BIT;
      end else if (wr_delta) begin
         bit_idx_r <= `BYTE_TOP_BIT;
      end else if (bit_tick) begin
         bit_idx_r <= bit_idx_r - 3'h1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmp_s1_r <= 1'h0;
         cmp_s2_r <= 1'h0;
      end else begin
         cmp_s1_r <= comparator_in;
         cmp_s2_r <= cmp_s1_r;
      end
   end

   // field views
   assign burst_sel = setup_r[`F_PCM_HI] & ~setup_r[`F_PCM_LO];
   assign host_sel  = setup_r[`F_PCM_HI] & setup_r[`F_PCM_LO];
   assign loop_src  = loop_src_e'(setup_r[`F_LOOP_HI:`F_LOOP_LO]);
   assign ldo_sel   = ldo_sel_e'(setup_r[`F_LDO_HI:`F_LDO_LO]);
   assign voice_src = voice_src_e'(setup_r[`F_VOUT_HI:`F_VOUT_LO]);

   // interpolator input path; a host word written while full is dropped
   always_comb begin
      pbuf.in_valid  = 1'h0;
      pbuf.in_data   = rx_pcm_word;
      pbuf.out_ready = interp_req & setup_r[`F_PCM_HI];
      if (burst_sel) begin
         pbuf.in_valid = rx_pcm_valid & rx_pcm_ready_r;
      end else if (host_sel) begin
         pbuf.in_valid = wr_dac;
         pbuf.in_data  = reg_wdata;
      end
   end

   // ready drops for a cycle after each push: costs rate, never a word
   assign rx_ready_nxt = burst_sel & pbuf.in_ready & ~pbuf.in_valid;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_pcm_ready_r <= 1'h0;
      end else begin
         rx_pcm_ready_r <= rx_ready_nxt;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         interp_pcm_word_r  <= 16'h0000;
         interp_pcm_valid_r <= 1'h0;
      end else begin
         interp_pcm_valid_r <= pbuf.out_valid & pbuf.out_ready;
         if (pbuf.out_valid && pbuf.out_ready) begin
            interp_pcm_word_r <= pbuf.out_data;
         end
      end
   end

   // filter direction and mode flags
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pcm_decimate_r    <= 1'h1;
         decim_by4_r       <= 1'h0;
         pcm_to_delta_r    <= 1'h0;
         delta_to_pcm_r    <= 1'h1;
         loop_open_r       <= 1'h0;
         direct_test_r     <= 1'h0;
         offset_track_en_r <= 1'h0;
      end else begin
         pcm_decimate_r    <= ~setup_r[`F_PCM_HI];
         decim_by4_r       <= setup_r[`F_DECIM];
         pcm_to_delta_r    <= setup_r[`F_PCM_HI];
         delta_to_pcm_r    <= ~setup_r[`F_PCM_HI];
         loop_open_r       <= (loop_src == LOOP_FROM_HOST);
         direct_test_r     <= (ldo_sel == LDO_DIRECT);
         offset_track_en_r <= setup_r[`F_IDLE];
      end
   end

   // time constants in bit periods
   always_comb begin
      decay_nxt  = `DECAY_BASE_BITS << setup_r[`F_DECAY_HI:`F_DECAY_LO];
      attack_nxt = decay_nxt >> (`ATTACK_MIN_SHIFT + {1'h0, setup_r[`F_ATK_HI:`F_ATK_LO]});
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         decay_bits_r  <= `DECAY_BASE_BITS;
         attack_bits_r <= `DECAY_BASE_BITS >> `ATTACK_MIN_SHIFT;
      end else begin
         decay_bits_r  <= decay_nxt;
         attack_bits_r <= attack_nxt;
      end
   end

   // encoder loop input, one bit per tick
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         loop_bit_r <= 1'h0;
      end else if (bit_tick) begin
         case (loop_src)
            LOOP_FROM_CMP: begin
               loop_bit_r <= cmp_s2_r;
            end
            LOOP_FROM_HOST: begin
               loop_bit_r <= byte_bit(delta_byte_r, bit_idx_r);
            end
            default: begin
               loop_bit_r <= feedback_bit;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         delta_out_r <= 1'h0;
      end else if (bit_tick) begin
         if (setup_r[`F_OVERRIDE]) begin
            delta_out_r <= byte_bit(delta_byte_r, bit_idx_r);
         end else begin
            delta_out_r <= encoded_bit;
         end
      end
   end

   // local decoder output; the sum wraps at 16 bits
   always_comb begin
      case (ldo_sel)
         LDO_EST: begin
            ldo_nxt = est_word;
         end
         LDO_SUM: begin
            ldo_nxt = est_word + interp_word;
         end
         LDO_DIRECT: begin
            ldo_nxt = dac_word_r;
         end
         default: begin
            ldo_nxt = interp_word;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         local_dec_word_r <= 16'h0000;
      end else begin
         local_dec_word_r <= ldo_nxt;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         voice_pin_r <= 1'h0;
      end else begin
         case (voice_src)
            VOICE_DETECT: begin
               voice_pin_r <= voice_detect;
            end
            VOICE_BITS: begin
               voice_pin_r <= delta_out_r;
            end
            VOICE_LOW: begin
               voice_pin_r <= 1'h0;
            end
            default: begin
               voice_pin_r <= 1'h1;
            end
         endcase
      end
   end

   default clocking cb @(posedge mclk);
   endclocking

   default disable iff (rst);

   a_decim_after_write: assert property (
      wr_setup |-> ##2 (pcm_decimate_r == !$past(reg_wdata[`F_PCM_HI], 2)))
      else $error("decimate flag does not follow bit 14");

   a_transcode_dir: assert property (
      pcm_to_delta_r == !delta_to_pcm_r && pcm_to_delta_r == !pcm_decimate_r)
      else $error("transcode direction disagrees with filter");

   a_loop_comparator: assert property (
      (bit_tick && loop_src == LOOP_FROM_CMP) |=> loop_bit_r == $past(cmp_s2_r))
      else $error("comparator bit not taken");

   a_loop_host_bits: assert property (
      (bit_tick && loop_src == LOOP_FROM_HOST)
      |=> loop_bit_r == $past(delta_byte_r[bit_idx_r]) ##1 loop_open_r)
      else $error("host bit not taken or loop not opened");

   a_loop_feedback: assert property (
      (bit_tick && setup_r[`F_LOOP_HI]) |=> loop_bit_r == $past(feedback_bit))
      else $error("feedback bit not taken");

   a_ldo_estimator: assert property (
      (ldo_sel == LDO_EST) |=> local_dec_word_r == $past(est_word))
      else $error("estimator not driven alone");

   a_ldo_sum: assert property (
      (ldo_sel == LDO_SUM) |=> local_dec_word_r == $past(est_word) + $past(interp_word))
      else $error("sum output wrong");

   a_ldo_interp: assert property (
      (ldo_sel == LDO_INTERP) |=> local_dec_word_r == $past(interp_word) && !direct_test_r)
      else $error("interpolated output wrong");

   a_idle_track: assert property (
      wr_setup |-> ##2 (offset_track_en_r == $past(reg_wdata[`F_IDLE], 2)))
      else $error("offset tracking does not follow bit 8");

   a_decay_value: assert property (
      (wr_setup && reg_wdata[`F_DECAY_HI:`F_DECAY_LO] == 3'h7) |-> ##2 decay_bits_r == 15'h4000)
      else $error("longest decay not 16384 periods");

   a_attack_ratio: assert property (
      (setup_r[`F_ATK_HI:`F_ATK_LO] == 2'h3 && $stable(setup_r))
      |=> attack_bits_r == (decay_bits_r >> 5))
      else $error("attack not decay over 32");

   a_voice_forced: assert property (
      (voice_src == VOICE_HIGH) |=> voice_pin_r)
      else $error("voice pin not held high");

   a_override_bits: assert property (
      (bit_tick && setup_r[`F_OVERRIDE]) |=> delta_out_r == $past(delta_byte_r[bit_idx_r]))
      else $error("override byte not sent");

   a_normal_bits: assert property (
      (bit_tick && !setup_r[`F_OVERRIDE]) |=> delta_out_r == $past(encoded_bit))
      else $error("encoded bit not sent");

   a_burst_no_loss: assert property (
      (rx_pcm_valid && rx_pcm_ready_r) |-> pbuf.in_ready && pbuf.in_valid)
      else $error("burst word taken while buffer full");

   a_decim_ratio: assert property (
      wr_setup |-> ##2 (decim_by4_r == $past(reg_wdata[`F_DECIM], 2)))
      else $error("ratio does not follow bit 15");

endmodule : enc_path_setup

`default_nettype wire

// *** tb/host_model.sv ***
// host controller model: drives the register port of the setup block
// assumes mclk is shared with the block and its read answer is registered
`default_nettype none

module host_model (
   input  wire logic        mclk,
   output logic      [7:0]  reg_addr,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata_r
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
   end

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      // released data must not echo the last word
      reg_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      d = reg_rdata_r;
   endtask : rd

   // trim level goes in first so tracking never starts from a stale offset
   task automatic track_on(input logic [15:0] s);
      wr(8'hE3, 16'h0004);
      // open-loop decoding is passed on without the tracking bit added
      wr(8'hE0, (s[12:11] == 2'h1) ? s : (s | 16'h0100));
   endtask : track_on

   task automatic idle_pattern(input logic [15:0] s);
      wr(8'hE8, 16'h0055);
      wr(8'hE0, s | 16'h0001);
   endtask : idle_pattern

endmodule : host_model

`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the encoder path setup block
// assumes host_model owns the register port; bench drives engine side
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        mclk, rst, bit_tick, comparator_in, feedback_bit;
   logic        encoded_bit, voice_detect, rx_pcm_valid, interp_req;
   logic [15:0] est_word, interp_word, rx_pcm_word, rd_v;
   logic [7:0]  reg_addr;
   logic        reg_wr, reg_rd;
   logic [15:0] reg_wdata, reg_rdata_r, interp_pcm_word_r, local_dec_word_r;
   logic        rx_pcm_ready_r, interp_pcm_valid_r, pcm_decimate_r, decim_by4_r;
   logic        pcm_to_delta_r, delta_to_pcm_r, loop_open_r, loop_bit_r;
   logic        direct_test_r, offset_track_en_r, voice_pin_r, delta_out_r;
   logic [14:0] decay_bits_r, attack_bits_r;
   int          bad_count, check_count;

   enc_path_setup uut (.mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata_r, .bit_tick, .comparator_in, .feedback_bit, .encoded_bit,
      .voice_detect, .est_word, .interp_word, .rx_pcm_word, .rx_pcm_valid,
      .rx_pcm_ready_r, .interp_req, .interp_pcm_word_r, .interp_pcm_valid_r,
      .pcm_decimate_r, .decim_by4_r, .pcm_to_delta_r, .delta_to_pcm_r,
      .loop_open_r, .loop_bit_r, .local_dec_word_r, .direct_test_r,
      .offset_track_en_r, .decay_bits_r, .attack_bits_r, .voice_pin_r,
      .delta_out_r);

   host_model h (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   // outputs are read right after an edge, so they hold last cycle's value
   task automatic put(input logic [7:0] a, input logic [15:0] d);
      h.wr(a, d);
      repeat (3) @(posedge mclk);
   endtask : put

   task automatic tick();
      @(posedge mclk);
      bit_tick <= 1'b1;
      @(posedge mclk);
      bit_tick <= 1'b0;
      @(posedge mclk);
   endtask : tick

   task automatic pop(input logic [15:0] w, input logic want);
      int i;
      logic hit;
      hit = 1'b0;
      @(posedge mclk);
      interp_req <= 1'b1;
      @(posedge mclk);
      interp_req <= 1'b0;
      for (i = 0; i < 4 && !hit; i++) begin
         @(posedge mclk);
         hit = (interp_pcm_valid_r === 1'b1);
      end
      chk("word valid", {15'h0, hit}, {15'h0, want});
      if (hit) chk("word", interp_pcm_word_r, w);
   endtask : pop

   task automatic push(input logic [15:0] w, input logic want);
      int i;
      logic took;
      took = 1'b0;
      @(posedge mclk);
      rx_pcm_valid <= 1'b1;
      rx_pcm_word <= w;
      for (i = 0; i < 4 && !took; i++) begin
         @(posedge mclk);
         took = (rx_pcm_ready_r === 1'b1);
      end
      rx_pcm_valid <= 1'b0;
      rx_pcm_word <= ~w;
      chk("burst taken", {15'h0, took}, {15'h0, want});
   endtask : push

   task automatic t_reset();
      @(posedge mclk);
      chk("decimate", {15'h0, pcm_decimate_r}, 16'h0001);
      chk("to pcm", {15'h0, delta_to_pcm_r}, 16'h0001);
      chk("decay", {1'b0, decay_bits_r}, 16'h0080);
      chk("attack", {1'b0, attack_bits_r}, 16'h0020);
      h.rd(8'hE0, rd_v);
      chk("setup reset", rd_v, 16'h0000);
   endtask : t_reset

   task automatic t_modes();
      int c;
      logic [15:0] w;
      for (c = 0; c < 8; c++) begin
         w = {c[2:0], 13'h0};
         put(8'hE0, w);
         chk("decimate", {15'h0, pcm_decimate_r}, {15'h0, ~w[14]});
         chk("ratio", {15'h0, decim_by4_r}, {15'h0, w[15]});
         chk("to delta", {15'h0, pcm_to_delta_r}, {15'h0, w[14]});
         chk("to pcm", {15'h0, delta_to_pcm_r}, {15'h0, ~w[14]});
         h.rd(8'hE0, rd_v);
         chk("readback", rd_v, w);
      end
      h.rd(8'h5A, rd_v);
      chk("unmapped", rd_v, 16'h0000);
   endtask : t_modes

   task automatic t_vad();
      int d, a;
      logic [15:0] dec;
      for (d = 0; d < 8; d++) begin
         for (a = 0; a < 4; a++) begin
            put(8'hE0, {8'h0, d[2:0], a[1:0], 3'h0});
            dec = 16'h0080 << d;
            chk("decay", {1'b0, decay_bits_r}, dec);
            chk("attack", {1'b0, attack_bits_r}, dec >> (2 + a));
         end
      end
      voice_detect <= 1'b1;
      put(8'hE0, 16'h0000);
      chk("voice det", {15'h0, voice_pin_r}, 16'h0001);
      put(8'hE0, 16'h0004);
      chk("voice low", {15'h0, voice_pin_r}, 16'h0000);
      voice_detect <= 1'b0;
      put(8'hE0, 16'h0006);
      chk("voice high", {15'h0, voice_pin_r}, 16'h0001);
   endtask : t_vad

   task automatic t_local();
      int s;
      for (s = 0; s < 2; s++) begin
         put(8'hE0, {5'h0, s[1:0], 9'h0});
         chk("local", local_dec_word_r, s ? 16'h5555 : 16'h1234);
      end
      put(8'hE0, 16'h0600);
      chk("local interp", local_dec_word_r, 16'h4321);
      put(8'hE0, 16'h6400);
      put(8'hE7, 16'hA5C3);
      chk("direct", {15'h0, direct_test_r}, 16'h0001);
      chk("local direct", local_dec_word_r, 16'hA5C3);
      pop(16'hA5C3, 1'b1);
   endtask : t_local

   task automatic t_bits();
      int i;
      put(8'hE0, 16'h0000);
      tick();
      chk("cmp bit", {15'h0, loop_bit_r}, 16'h0001);
      chk("normal out", {15'h0, delta_out_r}, 16'h0001);
      // filter interpolates for transcode input; analog side may sleep,
      // comparator left high so a wrong pick shows
      put(8'hE0, 16'h7000);
      tick();
      chk("fb bit", {15'h0, loop_bit_r}, 16'h0000);
      put(8'hE0, 16'h0800);
      chk("loop open", {15'h0, loop_open_r}, 16'h0001);
      // host bits on the loop and voice pin echoing output bits, one cycle late
      h.idle_pattern(16'h0802);
      for (i = 0; i < 8; i++) begin
         tick();
         chk("idle bit", {15'h0, delta_out_r}, i[0] ? 16'h0001 : 16'h0000);
         chk("host bit", {15'h0, loop_bit_r}, i[0] ? 16'h0001 : 16'h0000);
         chk("voice bits", {15'h0, voice_pin_r}, i[0] ? 16'h0000 : 16'h0001);
      end
      h.track_on(16'h0000);
      repeat (3) @(posedge mclk);
      chk("track on", {15'h0, offset_track_en_r}, 16'h0001);
      h.wr(8'hE3, 16'h0000);
      put(8'hE0, 16'h0000);
      chk("track off", {15'h0, offset_track_en_r}, 16'h0000);
   endtask : t_bits

   task automatic t_burst();
      put(8'hE0, 16'h4000);
      push(16'h1111, 1'b1);
      push(16'h2222, 1'b1);
      // full: a third word must wait without being lost
      push(16'h3333, 1'b0);
      pop(16'h1111, 1'b1);
      pop(16'h2222, 1'b1);
      // the refused word is offered again once room is made
      push(16'h3333, 1'b1);
      pop(16'h3333, 1'b1);
      pop(16'h0000, 1'b0);
   endtask : t_burst

   initial begin
      rst = 1'b1;
      bit_tick = 1'b0;
      comparator_in = 1'b1;
      feedback_bit = 1'b0;
      encoded_bit = 1'b1;
      voice_detect = 1'b0;
      est_word = 16'h1234;
      interp_word = 16'h4321;
      rx_pcm_word = 16'h0000;
      rx_pcm_valid = 1'b0;
      interp_req = 1'b0;
      bad_count = 0;
      check_count = 0;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_modes();
      t_vad();
      t_local();
      t_bits();
      t_burst();
      print_verdict();
   end

endmodule : testbench

`default_nettype wire
